//--- shared/mhb_pkg.sv
// Purpose: constants and types shared by the host bus emulator
// Assumes: 20 MHz system clock
// Notes:   mode values and command codes for the host-side port
`default_nettype none
package mhb_pkg;
    localparam logic [7:0] MHB_MODE_BUS     = 8'h08;
    localparam logic [7:0] MHB_MODE_DEFAULT = 8'h00;
    localparam logic [7:0] MHB_RESET_BYTE   = 8'h00;
    localparam logic [3:0] MHB_CLK_DIV      = 4'h4;
    localparam logic [3:0] MHB_CLK_DIV_ZERO = 4'h0;

    typedef enum logic [3:0] {
        MHB_OP_READ,
        MHB_OP_READ_EXT,
        MHB_OP_WRITE,
        MHB_OP_WRITE_EXT,
        MHB_OP_SET_MODE,
        MHB_OP_GPIO_SET,
        MHB_OP_GPIO_READ,
        MHB_OP_WAIT_HIGH,
        MHB_OP_WAIT_LOW
    } mhb_op_e;

    typedef enum logic [3:0] {
        MHB_IDLE,
        MHB_ADDR_HI,
        MHB_ALE,
        MHB_ADDR_HOLD,
        MHB_DATA_SETUP,
        MHB_STROBE,
        MHB_RECOVER,
        MHB_RESULT,
        MHB_WAIT_PIN
    } mhb_state_e;
endpackage : mhb_pkg
`default_nettype wire

//--- shared/mhb_sync_if.sv
// Purpose: carrier for synchronised pin inputs
// Assumes: one clock domain
// Notes:   filled by the synchroniser, read by the bus engine
`default_nettype none
interface mhb_sync_if;
    logic [7:0] bus_data;
    logic       stretch_n;
    logic       gp_zero;
    logic       gp_wait;
    modport src (output bus_data, output stretch_n, output gp_zero, output gp_wait);
    modport dst (input bus_data, input stretch_n, input gp_zero, input gp_wait);
endinterface : mhb_sync_if
`default_nettype wire

//--- verilog/mhb_sync.sv
// Purpose: two-stage synchroniser for all pin inputs
// Assumes: inputs are asynchronous to clock_in
// Notes:   first stage feeds only the second stage
`default_nettype none
module mhb_sync (
    // Clock and reset
    input  wire logic       clock_in,
    input  wire logic       rst_in,
    // Raw pins
    input  wire logic [7:0] bus_data_in,
    input  wire logic       stretch_n_in,
    input  wire logic       gp_zero_in,
    input  wire logic       gp_wait_in,
    // Synchronised
    mhb_sync_if.src         sync
);
    logic [10:0] meta_r;
    logic [10:0] stable_r;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            meta_r   <= 11'h7ff;
            stable_r <= 11'h7ff;
        end else begin
            meta_r   <= {bus_data_in, stretch_n_in, gp_zero_in, gp_wait_in};
            stable_r <= meta_r;
        end
    end

    assign sync.bus_data  = stable_r[10:3];
    assign sync.stretch_n = stable_r[2];
    assign sync.gp_zero   = stable_r[1];
    assign sync.gp_wait   = stable_r[0];
endmodule : mhb_sync
`default_nettype wire

//--- verilog/mhb_host_bus.sv
// Purpose: microcontroller host bus master driven by host commands
// Assumes: 20 MHz clock_in; peripheral pulls stretch pin high when unused
// Notes:   bus phases advance on a divided enable, also shown on bus_clk_out
// ****************************************************************
// How it works
// R1 - Both channels' pins together form one host bus that this block masters.
// R2 - The low eight lines carry the low address byte, then the data byte.
// R3 - Eight output-only lines hold the upper address byte.
// R4 - Plain read and write keep the upper address and send only a low byte.
// R5 - Extended read and write first load the upper address, then access.
// R6 - Mode value 08 enables bus emulation and value 00 returns to default.
// R7 - General pin zero is settable, clearable and readable in bus mode.
// R8 - General pin wait is settable and readable and can stall until high or low.
// R9 - The commander keeps the wait pin an input while waiting on its level; here the wait ops leave gp_wait_oe_n_out as the last GPIO set made it.
// R10 - A low stretch input lengthens the cycle; it must idle high.
// R11 - Chip select is a low pulse spanning each access.
// R12 - Write data is placed on the lines before the write strobe goes low.
// R13 - The read strobe is driven on reads and data sampled while it is low.
// R14 - An output shows the clock the bus logic uses.
// R15 - Each access opens with an address phase marked by a high latch strobe.
// R16 - Read data returns to the command source before the next operation.
// ****************************************************************
`default_nettype none
module mhb_host_bus
    import mhb_pkg::*;
(
    // Clock and reset
    input  wire logic       clock_in,
    input  wire logic       rst_in,
    // Command port
    input  wire logic       cmd_valid_in,
    input  wire logic [3:0] cmd_op_in,
    input  wire logic [7:0] cmd_addr_lo_in,
    input  wire logic [7:0] cmd_addr_hi_in,
    input  wire logic [7:0] cmd_data_in,
    output logic            cmd_ready_out,
    output logic            rsp_valid_out,
    output logic [7:0]      rsp_data_out,
    output logic            mode_active_out,
    // Multiplexed bus
    input  wire logic [7:0] bus_data_in,
    output logic [7:0]      bus_data_out,
    output logic            bus_data_oe_n_out,
    output logic [7:0]      upper_addr_out,
    output logic            chip_sel_n_out,
    output logic            read_n_out,
    output logic            write_n_out,
    output logic            addr_latch_out,
    output logic            bus_clk_out,
    input  wire logic       cycle_stretch_n_in,
    // General pins
    input  wire logic       gp_zero_in,
    output logic            gp_zero_out,
    output logic            gp_zero_oe_n_out,
    input  wire logic       gp_wait_in,
    output logic            gp_wait_out,
    output logic            gp_wait_oe_n_out
);
    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    mhb_sync_if sync ();

    mhb_sync u_sync (
        .clock_in     (clock_in),
        .rst_in       (rst_in),
        .bus_data_in  (bus_data_in),
        .stretch_n_in (cycle_stretch_n_in),
        .gp_zero_in   (gp_zero_in),
        .gp_wait_in   (gp_wait_in),
        .sync         (sync)
    );

    // ****************************************************************
    // Bus clock divider
    // ****************************************************************
    logic [3:0] div_r;
    logic       bclk_r;
    wire        tick = (div_r == MHB_CLK_DIV_ZERO);

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            div_r  <= MHB_CLK_DIV_ZERO;
            bclk_r <= 1'b0;
        end else begin
            div_r  <= tick ? MHB_CLK_DIV - 4'h1 : div_r - 4'h1;
            bclk_r <= tick ? ~bclk_r : bclk_r;
        end
    end
    assign bus_clk_out = bclk_r;                              // [R14]

    // ****************************************************************
    // Command decode
    // ****************************************************************
    mhb_state_e state_r;
    logic       mode_r;
    mhb_op_e    op_r;
    logic [7:0] lo_r;
    logic [7:0] hi_pend_r;
    logic [7:0] data_r;
    logic [7:0] upper_r;
    logic [7:0] rsp_r;
    logic       rsp_v_r;
    logic [1:0] gp_val_r;
    logic [1:0] gp_oe_n_r;
    logic       wait_lvl_r;

    wire       idle      = (state_r == MHB_IDLE);
    wire       take      = cmd_valid_in && idle && !rsp_v_r;     // [R16]
    wire       cmd_mode  = (cmd_op_in == MHB_OP_SET_MODE);
    wire       is_bus_op = (cmd_op_in <= MHB_OP_WRITE_EXT);
    wire       is_ext    = (cmd_op_in == MHB_OP_READ_EXT) || (cmd_op_in == MHB_OP_WRITE_EXT);
    wire       is_read   = (op_r == MHB_OP_READ) || (op_r == MHB_OP_READ_EXT);
    wire       stretched = !sync.stretch_n;                       // [R10]
    wire       pin_hit   = (sync.gp_wait == wait_lvl_r);          // [R8]

    assign cmd_ready_out   = idle && !rsp_v_r;
    assign mode_active_out = mode_r;
    assign rsp_valid_out   = rsp_v_r;
    assign rsp_data_out    = rsp_r;

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_r    <= MHB_IDLE;
            mode_r     <= 1'b0;
            op_r       <= MHB_OP_READ;
            lo_r       <= MHB_RESET_BYTE;
            hi_pend_r  <= MHB_RESET_BYTE;
            data_r     <= MHB_RESET_BYTE;
            upper_r    <= MHB_RESET_BYTE;
            rsp_r      <= MHB_RESET_BYTE;
            rsp_v_r    <= 1'b0;
            gp_val_r   <= 2'b00;
            gp_oe_n_r  <= 2'b11;
            wait_lvl_r <= 1'b0;
        end else begin
            rsp_v_r <= 1'b0;
            if (take) begin
                op_r      <= mhb_op_e'(cmd_op_in);
                lo_r      <= cmd_addr_lo_in;
                hi_pend_r <= cmd_addr_hi_in;
                data_r    <= cmd_data_in;
                if (cmd_mode) begin
                    if (cmd_data_in == MHB_MODE_BUS) begin
                        mode_r <= 1'b1;                           // [R6]
                    end else if (cmd_data_in == MHB_MODE_DEFAULT) begin
                        mode_r <= 1'b0;                           // [R6]
                    end
                end else if (mode_r && is_bus_op) begin
                    state_r <= is_ext ? MHB_ADDR_HI : MHB_ALE;    // [R4] [R5]
                end else if (mode_r && cmd_op_in == MHB_OP_GPIO_SET) begin
                    gp_val_r  <= cmd_data_in[1:0];                // [R7] [R8]
                    gp_oe_n_r <= ~cmd_addr_lo_in[1:0];
                end else if (mode_r && cmd_op_in == MHB_OP_GPIO_READ) begin
                    rsp_r   <= {6'h00, sync.gp_wait, sync.gp_zero}; // [R7] [R8]
                    rsp_v_r <= 1'b1;
                end else if (mode_r && (cmd_op_in == MHB_OP_WAIT_HIGH ||
                                        cmd_op_in == MHB_OP_WAIT_LOW)) begin
                    wait_lvl_r <= (cmd_op_in == MHB_OP_WAIT_HIGH);
                    state_r    <= MHB_WAIT_PIN;                   // [R8] [R9]
                end
            end else if (tick) begin
                unique case (state_r)
                    MHB_IDLE: begin
                    end
                    MHB_ADDR_HI: begin
                        upper_r <= hi_pend_r;                     // [R3] [R5]
                        state_r <= MHB_ALE;
                    end
                    MHB_ALE:        state_r <= MHB_ADDR_HOLD;     // [R15]
                    MHB_ADDR_HOLD:  state_r <= MHB_DATA_SETUP;
                    MHB_DATA_SETUP: state_r <= MHB_STROBE;        // [R12]
                    MHB_STROBE: begin
                        if (!stretched) begin                     // [R10]
                            if (is_read) begin
                                rsp_r <= sync.bus_data;           // [R13]
                            end
                            state_r <= MHB_RECOVER;
                        end
                    end
                    MHB_RECOVER: state_r <= is_read ? MHB_RESULT : MHB_IDLE;
                    MHB_RESULT: begin
                        rsp_v_r <= 1'b1;                          // [R16]
                        state_r <= MHB_IDLE;
                    end
                    MHB_WAIT_PIN: begin
                        if (pin_hit) begin
                            state_r <= MHB_IDLE;                  // [R8]
                        end
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Pin drive
    // ****************************************************************
    logic [7:0] ad_out_r;
    logic       ad_oe_n_r;
    logic       cs_n_r;
    logic       rd_n_r;
    logic       wr_n_r;
    logic       ale_r;

    wire in_access = (state_r == MHB_ALE) || (state_r == MHB_ADDR_HOLD) ||
                     (state_r == MHB_DATA_SETUP) || (state_r == MHB_STROBE);
    wire addr_ph   = (state_r == MHB_ALE) || (state_r == MHB_ADDR_HOLD);
    wire data_ph   = (state_r == MHB_DATA_SETUP) || (state_r == MHB_STROBE);

    // Registered pins avoid glitches on the strobes
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ad_out_r  <= MHB_RESET_BYTE;
            ad_oe_n_r <= 1'b1;
            cs_n_r    <= 1'b1;
            rd_n_r    <= 1'b1;
            wr_n_r    <= 1'b1;
            ale_r     <= 1'b0;
        end else begin
            ad_out_r  <= addr_ph ? lo_r : data_r;                 // [R2]
            ad_oe_n_r <= !(addr_ph || (data_ph && !is_read));     // [R12]
            cs_n_r    <= !in_access;                              // [R11]
            ale_r     <= (state_r == MHB_ALE);                    // [R15]
            rd_n_r    <= !(state_r == MHB_STROBE && is_read);     // [R13]
            wr_n_r    <= !(state_r == MHB_STROBE && !is_read);    // [R12]
        end
    end

    assign bus_data_out      = ad_out_r;                          // [R1]
    assign bus_data_oe_n_out = ad_oe_n_r;
    assign upper_addr_out    = upper_r;                           // [R3] [R4]
    assign chip_sel_n_out    = cs_n_r;
    assign read_n_out        = rd_n_r;
    assign write_n_out       = wr_n_r;
    assign addr_latch_out    = ale_r;
    assign gp_zero_out       = gp_val_r[0];
    assign gp_zero_oe_n_out  = gp_oe_n_r[0];
    assign gp_wait_out       = gp_val_r[1];
    assign gp_wait_oe_n_out  = gp_oe_n_r[1];
endmodule : mhb_host_bus
`default_nettype wire

//--- tb/mhb_host_bus_properties.sv
// Purpose: port-level checks for mhb_host_bus
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound into every mhb_host_bus instance
`default_nettype none
module mhb_host_bus_chk
    import mhb_pkg::*;
(
    // Clock, reset, command port, upper address and data enable
    input wire logic       clock_in, rst_in, cmd_valid_in, cmd_ready_out,
    input wire logic [3:0] cmd_op_in,
    input wire logic [7:0] cmd_data_in, upper_addr_out,
    input wire logic       rsp_valid_out, mode_active_out, bus_data_oe_n_out,
    // Strobes and bus clock
    input wire logic       chip_sel_n_out, read_n_out, write_n_out,
    input wire logic       addr_latch_out, bus_clk_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    wire mode_take = cmd_valid_in && cmd_ready_out && cmd_op_in == MHB_OP_SET_MODE;
    // ****************************************************************
    // Properties
    // ****************************************************************
    property p_mode_on;
        mode_take && cmd_data_in == MHB_MODE_BUS |=> mode_active_out;
    endproperty
    a_mode_on: assert property (p_mode_on) else $error("mode not entered");
    property p_mode_off;
        mode_take && cmd_data_in == MHB_MODE_DEFAULT |=> !mode_active_out;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("mode not left");
    property p_cs_span;
        !(read_n_out && write_n_out) |-> !chip_sel_n_out;
    endproperty
    a_cs_span: assert property (p_cs_span) else $error("strobe outside select");
    property p_wr_data;
        $fell(write_n_out) |-> !bus_data_oe_n_out && !$past(bus_data_oe_n_out);
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("write data late");
    property p_rd_release;
        !read_n_out |-> bus_data_oe_n_out && write_n_out;
    endproperty
    a_rd_release: assert property (p_rd_release) else $error("bus driven in read");
    property p_ale_first;
        $fell(chip_sel_n_out) |-> addr_latch_out;
    endproperty
    a_ale_first: assert property (p_ale_first) else $error("no address phase");
    property p_upper_hold;
        !chip_sel_n_out |-> $stable(upper_addr_out);
    endproperty
    a_upper_hold: assert property (p_upper_hold) else $error("upper moved");
    property p_bus_clk;
        $changed(bus_clk_out) |=> $stable(bus_clk_out) [*3];
    endproperty
    a_bus_clk: assert property (p_bus_clk) else $error("bus clock rate");
    property p_rsp_pulse;
        rsp_valid_out |=> !rsp_valid_out;
    endproperty
    a_rsp_pulse: assert property (p_rsp_pulse) else $error("response too long");
    property p_busy;
        !chip_sel_n_out |-> !cmd_ready_out;
    endproperty
    a_busy: assert property (p_busy) else $error("ready during access");
    c_read: cover property ($fell(read_n_out));
    c_write: cover property ($fell(write_n_out));
    c_rsp: cover property (rsp_valid_out);
endmodule // mhb_host_bus_chk
bind mhb_host_bus mhb_host_bus_chk u_chk (.clock_in, .rst_in, .cmd_valid_in, .cmd_ready_out,
    .cmd_op_in, .cmd_data_in, .upper_addr_out, .rsp_valid_out, .mode_active_out,
    .bus_data_oe_n_out, .chip_sel_n_out, .read_n_out, .write_n_out, .addr_latch_out,
    .bus_clk_out);
`default_nettype wire

//--- tb/mhb_periph_model.sv
// Purpose: peripheral on the multiplexed host bus
// Assumes: address taken while the latch strobe is high
// Notes:   released lines toggle so a stale value cannot pass
`default_nettype none
module mhb_periph_model (
    input  wire logic       clock_in, bus_data_oe_n_out, chip_sel_n_out,
    input  wire logic [7:0] bus_data_out, upper_addr_out,
    input  wire logic       read_n_out, write_n_out, addr_latch_out, stretch_en_in,
    output logic [7:0]      bus_data_in, wdata_q_out,
    output logic            cycle_stretch_n_in,
    output logic [15:0]     addr_q_out,
    output int              n_acc_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] drv_r = 8'h5A;
    logic [3:0] hold_r = 4'h0;
    logic       ale_r = 1'b0;
    logic       rd_r = 1'b1;
    initial n_acc_out = 0;
    always @(posedge clock_in) begin
        ale_r <= addr_latch_out;
        rd_r <= read_n_out;
        if (addr_latch_out) addr_q_out <= {upper_addr_out, bus_data_out};
        if (addr_latch_out && !ale_r) n_acc_out <= n_acc_out + 1;
        if (!chip_sel_n_out && !write_n_out) wdata_q_out <= bus_data_out;
        drv_r <= ~drv_r;
        if (stretch_en_in && !read_n_out && rd_r) hold_r <= 4'hC;
        else if (hold_r != 4'h0) hold_r <= hold_r - 4'h1;
    end
    // Pulled low at once by the read strobe, as an asynchronous part would
    wire stretch_on = !read_n_out && (rd_r || hold_r != 4'h0);
    assign cycle_stretch_n_in = !(stretch_en_in && stretch_on);
    // Read data follows the strobe with no clock of delay
    wire rd_sel = !chip_sel_n_out && !read_n_out;
    assign bus_data_in = !bus_data_oe_n_out ? bus_data_out :
                         rd_sel ? (addr_q_out[7:0] ^ 8'h3C) : drv_r;
endmodule // mhb_periph_model
`default_nettype wire

//--- tb/test_mcu_host_bus_emulator.sv
// Purpose: self-checking bench for mhb_host_bus
// Assumes: peripheral model answers reads with low address xor 3C
// Notes:   one task per scenario
`default_nettype none
module test_mcu_host_bus_emulator
    import mhb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic cmd_valid_in = 1'b0;
    logic gp_zero_in = 1'b0;
    logic gp_wait_in = 1'b0;
    logic stretch_en_in = 1'b0;
    logic [3:0] cmd_op_in = 4'h0;
    logic [7:0] cmd_addr_lo_in = 8'h00, cmd_addr_hi_in = 8'h00, cmd_data_in = 8'h00;
    logic cmd_ready_out, rsp_valid_out, mode_active_out, bus_data_oe_n_out, chip_sel_n_out;
    logic read_n_out, write_n_out, addr_latch_out, bus_clk_out, cycle_stretch_n_in;
    logic gp_zero_out, gp_zero_oe_n_out, gp_wait_out, gp_wait_oe_n_out;
    logic [7:0] rsp_data_out, bus_data_in, bus_data_out, upper_addr_out, wdata_q_out, r;
    logic [15:0] addr_q_out;
    int n_acc_out, num_errors = 0, checks_done = 0, cyc = 0, rd_low = 0, t0;
    mhb_host_bus u_dut (.clock_in, .rst_in, .cmd_valid_in, .cmd_op_in, .cmd_addr_lo_in,
        .cmd_addr_hi_in, .cmd_data_in, .cmd_ready_out, .rsp_valid_out, .rsp_data_out,
        .mode_active_out, .bus_data_in, .bus_data_out, .bus_data_oe_n_out, .upper_addr_out,
        .chip_sel_n_out, .read_n_out, .write_n_out, .addr_latch_out, .bus_clk_out,
        .cycle_stretch_n_in, .gp_zero_in, .gp_zero_out, .gp_zero_oe_n_out, .gp_wait_in,
        .gp_wait_out, .gp_wait_oe_n_out);
    mhb_periph_model u_periph (.clock_in, .bus_data_oe_n_out, .chip_sel_n_out, .bus_data_out,
        .upper_addr_out, .read_n_out, .write_n_out, .addr_latch_out, .stretch_en_in,
        .bus_data_in, .wdata_q_out, .cycle_stretch_n_in, .addr_q_out, .n_acc_out);
    initial begin
        forever #25 clock_in = ~clock_in;
    end
    // Run ceiling far above the few hundred cycles the tests need
    always @(posedge clock_in) begin
        cyc++;
        if (!read_n_out) rd_low++;
        if (cyc == 20000) begin
            num_errors++;
            results();
        end
    end
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [3:0] op, input logic [7:0] lo, hi, d);
        cmd_op_in <= op;
        cmd_addr_lo_in <= lo;
        cmd_addr_hi_in <= hi;
        cmd_data_in <= d;
        cmd_valid_in <= 1'b1;
        do @(posedge clock_in); while (cmd_ready_out !== 1'b1);
        cmd_valid_in <= 1'b0;
    endtask
    // Waits for the op to finish, keeping any response byte
    task automatic fin();
        int n;
        n = 0;
        do begin
            @(posedge clock_in);
            n++;
            if (rsp_valid_out === 1'b1) r = rsp_data_out;
        end while (cmd_ready_out !== 1'b1 && n < 500);
        if (n >= 500) num_errors++;
    endtask
    task automatic run(input logic [3:0] op, input logic [7:0] lo, hi, d);
        cmd(op, lo, hi, d);
        fin();
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_mode();
        run(MHB_OP_WRITE, 8'h11, 8'h00, 8'h22);
        chk(n_acc_out, 0);
        run(MHB_OP_SET_MODE, 8'h00, 8'h00, 8'h05);
        chk(mode_active_out, 0);
        run(MHB_OP_SET_MODE, 8'h00, 8'h00, 8'h08);
        chk(mode_active_out, 1);
        $display("t_mode done");
    endtask
    task automatic t_write();
        run(MHB_OP_WRITE_EXT, 8'h34, 8'h12, 8'h5A);
        chk(upper_addr_out, 8'h12);
        chk(addr_q_out, 16'h1234);
        chk(wdata_q_out, 8'h5A);
        run(MHB_OP_WRITE, 8'h56, 8'hEE, 8'hA3);
        chk(addr_q_out, 16'h1256);
        chk(wdata_q_out, 8'hA3);
        chk(n_acc_out, 2);
        $display("t_write done");
    endtask
    task automatic t_read();
        rd_low = 0;
        run(MHB_OP_READ_EXT, 8'h0F, 8'hA5, 8'h00);
        t0 = rd_low;
        chk(r, 8'h33);
        chk(addr_q_out, 16'hA50F);
        stretch_en_in <= 1'b1;
        rd_low = 0;
        run(MHB_OP_READ, 8'hF0, 8'h00, 8'h00);
        chk(r, 8'hCC);
        chk(upper_addr_out, 8'hA5);
        chk(rd_low >= t0 + 4, 1);
        stretch_en_in <= 1'b0;
        $display("t_read done");
    endtask
    task automatic t_gpio();
        gp_zero_in <= 1'b1;
        run(MHB_OP_GPIO_SET, 8'h03, 8'h00, 8'h02);
        chk({gp_zero_oe_n_out, gp_zero_out, gp_wait_oe_n_out, gp_wait_out}, 4'h1);
        run(MHB_OP_GPIO_SET, 8'h01, 8'h00, 8'h01);
        chk({gp_zero_oe_n_out, gp_zero_out, gp_wait_oe_n_out}, 3'h3);
        run(MHB_OP_GPIO_READ, 8'h00, 8'h00, 8'h00);
        chk(r, 8'h01);
        $display("t_gpio done");
    endtask
    task automatic t_wait();
        cmd(MHB_OP_WAIT_HIGH, 8'h00, 8'h00, 8'h00);
        repeat (20) @(posedge clock_in);
        chk(cmd_ready_out, 0);
        gp_wait_in <= 1'b1;
        fin();
        cmd(MHB_OP_WAIT_LOW, 8'h00, 8'h00, 8'h00);
        repeat (20) @(posedge clock_in);
        chk(cmd_ready_out, 0);
        gp_wait_in <= 1'b0;
        fin();
        run(MHB_OP_SET_MODE, 8'h00, 8'h00, 8'h00);
        chk(mode_active_out, 0);
        $display("t_wait done");
    endtask
    initial begin
        repeat (3) @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in);
        t_mode();
        t_write();
        t_read();
        t_gpio();
        t_wait();
        results();
    end
endmodule // test_mcu_host_bus_emulator
`default_nettype wire
